// file: shared/sbw_defs.svh
// constants for the sram byte write mask block
`ifndef SBW_DEFS_SVH
`define SBW_DEFS_SVH

// -------------------------------------------------------------------
// array geometry
// -------------------------------------------------------------------
`define SBW_ADDR_W      6
`define SBW_IDX_W       7
`define SBW_DATA_W      36
`define SBW_SEL_W       4
`define SBW_HSEL_W      2
`define SBW_LANE_W      9
`define SBW_NIB_W       4

// -------------------------------------------------------------------
// variant data widths
// -------------------------------------------------------------------
`define SBW_X8_BITS     8
`define SBW_X9_BITS     9
`define SBW_X18_BITS    18
`define SBW_X36_BITS    36

// -------------------------------------------------------------------
// buffering, counters and reset values
// -------------------------------------------------------------------
`define SBW_FIFO_DEPTH  4
`define SBW_CNT_W       16
`define SBW_RST_DATA    36'h0_0000_0000
`define SBW_RST_CNT     16'h0000

`endif

// file: shared/sbw_pkg.sv
// types shared by the sram byte write mask block
`default_nettype none
package sbw_pkg;
`include "sbw_defs.svh"

  typedef enum logic [1:0] {
    SBW_X8  = 2'b00,
    SBW_X9  = 2'b01,
    SBW_X18 = 2'b10,
    SBW_X36 = 2'b11
  } sbw_width_t;

  typedef enum logic [1:0] {
    SBW_ST_IDLE  = 2'b00,
    SBW_ST_BEAT1 = 2'b01
  } sbw_state_t;

  // one posted beat: where it goes, how wide, which lanes, what data
  typedef struct packed {
    logic [`SBW_ADDR_W-1:0] addr;
    logic                   beat;
    sbw_width_t             width;
    logic [`SBW_SEL_W-1:0]  sel_n;
    logic [`SBW_DATA_W-1:0] data;
  } sbw_entry_t;

endpackage
`default_nettype wire

// file: hdl/sbw_fifo.sv
// small synchronous fifo for posted write beats
`timescale 1ns/1ns
`default_nettype none
module sbw_fifo #(
  parameter int W     = 49,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic         clk_sys_in,
  input  wire logic         resetn_in,
  // fill side
  input  wire logic [W-1:0] in_data_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  // drain side
  output logic [W-1:0]      out_data_out,
  output logic              out_valid_out,
  input  wire logic         out_ready_in
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wr_ptr;
    logic [PW-1:0]           rd_ptr;
    logic [PW:0]             count;
  } sbw_fifo_state_t;

  sbw_fifo_state_t s_ff;
  sbw_fifo_state_t nxt_s;
  logic            push;
  logic            pop;

  assign in_ready_out  = (s_ff.count != (PW+1)'(DEPTH));
  assign out_valid_out = (s_ff.count != '0);
  assign out_data_out  = s_ff.mem[s_ff.rd_ptr];

  always_comb begin
    nxt_s = s_ff;
    push  = in_valid_in & in_ready_out;
    pop   = out_valid_out & out_ready_in;
    if (push) begin
      nxt_s.mem[s_ff.wr_ptr] = in_data_in;
      nxt_s.wr_ptr = (s_ff.wr_ptr == PW'(DEPTH - 1)) ? '0 : s_ff.wr_ptr + PW'(1);
    end
    if (pop) begin
      nxt_s.rd_ptr = (s_ff.rd_ptr == PW'(DEPTH - 1)) ? '0 : s_ff.rd_ptr + PW'(1);
    end
    if (push && !pop) begin
      nxt_s.count = s_ff.count + (PW+1)'(1);
    end else if (pop && !push) begin
      nxt_s.count = s_ff.count - (PW+1)'(1);
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule // sbw_fifo
`default_nettype wire

// file: hdl/sbw_lane_merge.sv
// per-bit lane enable decode and merge of new beat into stored word
`timescale 1ns/1ns
`default_nettype none
`include "sbw_defs.svh"
module sbw_lane_merge (
  // beat description
  input  wire sbw_pkg::sbw_width_t        width_in,
  input  wire logic [`SBW_SEL_W-1:0]      sel_n_in,
  input  wire logic [`SBW_DATA_W-1:0]     new_in,
  // stored word
  input  wire logic [`SBW_DATA_W-1:0]     old_in,
  // result
  output logic [`SBW_DATA_W-1:0]          merged_out,
  output logic [`SBW_DATA_W-1:0]          lane_en_out
);
  import sbw_pkg::*;

  genvar gi;
  for (gi = 0; gi < `SBW_DATA_W; gi++) begin : g_bit
    localparam int NIB  = gi / `SBW_NIB_W;
    localparam int LANE = gi / `SBW_LANE_W;
    logic en;
    // select low enables the lane, high masks it
    always_comb begin
      case (width_in)
        SBW_X8:  en = (gi < `SBW_X8_BITS)  ? ~sel_n_in[NIB % `SBW_HSEL_W] : 1'b0;
        SBW_X9:  en = (gi < `SBW_X9_BITS)  ? ~sel_n_in[0] : 1'b0;
        SBW_X18: en = (gi < `SBW_X18_BITS) ? ~sel_n_in[LANE % `SBW_HSEL_W] : 1'b0;
        SBW_X36: en = ~sel_n_in[LANE % `SBW_SEL_W];
        default: en = 1'b0;
      endcase
    end
    // unselected bits keep what is stored
    assign merged_out[gi]  = en ? new_in[gi] : old_in[gi];
    assign lane_en_out[gi] = en;
  end
endmodule // sbw_lane_merge
`default_nettype wire

// file: hdl/sbw_top.sv
// byte lane write mask front end with posted-write buffer and array
// -------------------------------------------------------------------
// Overview of operation
// - x8: both nibble selects low write all
// - x8: select0 only writes bits 3..0
// - x8: select1 only writes bits 7..4
// - x18: both selects low write all 18
// - x18: select0 only writes bits 8..0
// - x18: select1 only writes bits 17..9
// - all selects high: beat writes nothing
// - x9: single select low writes bits 8..0
// - x36: all four selects low write all
// - x36: select0 only writes bits 8..0
// - x36: selects 1..3 enable upper bytes
// - each beat uses its own selects
// - selects sampled on K and K-bar rises
// -------------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
`include "sbw_defs.svh"
module sbw_top (
  // clock and reset
  input  wire logic                         clk_sys_in,
  input  wire logic                         resetn_in,
  // memory pins from the controller
  input  wire logic                         k_in,
  input  wire logic                         k_bar_in,
  input  wire logic                         load_strobe_n_in,
  input  wire logic                         read_write_n_in,
  input  wire logic [`SBW_ADDR_W-1:0]       addr_in,
  input  wire logic [`SBW_DATA_W-1:0]       data_in,
  input  wire logic [`SBW_SEL_W-1:0]        lane_write_select_n_in,
  input  wire logic [`SBW_HSEL_W-1:0]       half_word_write_select_n_in,
  // configuration
  input  wire sbw_pkg::sbw_width_t          width_sel_in,
  input  wire logic                         overflow_clr_in,
  // array inspection port
  input  wire logic                         peek_en_in,
  input  wire logic [`SBW_IDX_W-1:0]        peek_idx_in,
  output logic [`SBW_DATA_W-1:0]            peek_data_out,
  output logic                              peek_valid_out,
  // status
  output logic                              posted_pending_out,
  output logic                              overflow_out,
  output logic [`SBW_CNT_W-1:0]             beats_written_out
);
  import sbw_pkg::*;

  // -------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------
  typedef struct packed {
    logic                   k;
    logic                   k_bar;
    logic                   load_n;
    logic                   rw_n;
    logic [`SBW_ADDR_W-1:0] addr;
    logic [`SBW_DATA_W-1:0] data;
    logic [`SBW_SEL_W-1:0]  lane_sel_n;
    logic [`SBW_HSEL_W-1:0] half_sel_n;
  } sbw_pins_t;

  typedef struct packed {
    sbw_pins_t              sync1;
    sbw_pins_t              sync2;
    logic                   k_prev;
    logic                   k_bar_prev;
    sbw_state_t             state;
    logic                   pend_valid;
    logic [`SBW_ADDR_W-1:0] pend_addr;
    logic [`SBW_ADDR_W-1:0] cur_addr;
    logic                   push_valid;
    sbw_entry_t             push_entry;
    logic [`SBW_DATA_W-1:0] peek_data;
    logic                   peek_valid;
    logic                   pending;
    logic                   overflow;
    logic [`SBW_CNT_W-1:0]  beats;
  } sbw_state_all_t;

  // -------------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------------
  sbw_state_all_t         s_ff;
  sbw_state_all_t         nxt_s;
  sbw_pins_t              pins;
  logic                   k_rise;
  logic                   k_bar_rise;
  logic                   wr_cmd;
  logic [`SBW_SEL_W-1:0]  beat_sel_n;
  sbw_entry_t             fifo_out;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic                   drain;
  logic [`SBW_IDX_W-1:0]  commit_idx;
  logic [`SBW_DATA_W-1:0] commit_old;
  logic [`SBW_DATA_W-1:0] commit_new;
  logic [`SBW_DATA_W-1:0] peek_word;

  // two words per burst address, one array row per beat
  logic [`SBW_DATA_W-1:0] array_mem [0:(1 << `SBW_IDX_W)-1];

  // -------------------------------------------------------------------
  // pin bundle and edge detection
  // -------------------------------------------------------------------
  always_comb begin
    pins.k          = k_in;
    pins.k_bar      = k_bar_in;
    pins.load_n     = load_strobe_n_in;
    pins.rw_n       = read_write_n_in;
    pins.addr       = addr_in;
    pins.data       = data_in;
    pins.lane_sel_n = lane_write_select_n_in;
    pins.half_sel_n = half_word_write_select_n_in;
  end

  // rises are seen on the second sync stage; data rides the same
  // stages so it lines up with the clock that strobed it
  assign k_rise     = s_ff.sync2.k & ~s_ff.k_prev;
  assign k_bar_rise = s_ff.sync2.k_bar & ~s_ff.k_bar_prev;
  assign wr_cmd     = ~s_ff.sync2.load_n & ~s_ff.sync2.rw_n;

  // -------------------------------------------------------------------
  // select gathering per variant
  // -------------------------------------------------------------------
  // unused select positions are forced high so they can never enable
  always_comb begin
    case (width_sel_in)
      SBW_X8:  beat_sel_n = {2'h3, s_ff.sync2.half_sel_n};
      SBW_X9:  beat_sel_n = {3'h7, s_ff.sync2.lane_sel_n[0]};
      SBW_X18: beat_sel_n = {2'h3, s_ff.sync2.lane_sel_n[1:0]};
      SBW_X36: beat_sel_n = s_ff.sync2.lane_sel_n;
      default: beat_sel_n = 4'hF;
    endcase
  end

  // -------------------------------------------------------------------
  // posted write buffer
  // -------------------------------------------------------------------
  sbw_fifo #(
    .W     ($bits(sbw_entry_t)),
    .DEPTH (`SBW_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .resetn_in     (resetn_in),
    .in_data_in    (s_ff.push_entry),
    .in_valid_in   (s_ff.push_valid),
    .in_ready_out  (fifo_in_ready),
    .out_data_out  (fifo_out),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (drain)
  );

  // inspection reads own the array port; posted beats wait behind them
  assign drain      = fifo_out_valid & ~peek_en_in;
  assign commit_idx = {fifo_out.addr, fifo_out.beat};
  assign commit_old = array_mem[commit_idx];
  assign peek_word  = array_mem[peek_idx_in];

  // -------------------------------------------------------------------
  // lane merge of the beat at the head of the buffer
  // -------------------------------------------------------------------
  // masks come from the entry, not from the pins, so a deferred beat
  // commits with the lanes it was written with
  sbw_lane_merge u_merge (
    .width_in    (fifo_out.width),
    .sel_n_in    (fifo_out.sel_n),
    .new_in      (fifo_out.data),
    .old_in      (commit_old),
    .merged_out  (commit_new),
    .lane_en_out ()
  );

  // no reset: the array holds data, not control state
  always_ff @(posedge clk_sys_in) begin
    if (drain) begin
      array_mem[commit_idx] <= commit_new;
    end
  end

  // -------------------------------------------------------------------
  // capture sequence
  // -------------------------------------------------------------------
  always_comb begin
    nxt_s            = s_ff;
    nxt_s.sync1      = pins;
    nxt_s.sync2      = s_ff.sync1;
    nxt_s.k_prev     = s_ff.sync2.k;
    nxt_s.k_bar_prev = s_ff.sync2.k_bar;
    nxt_s.push_valid = 1'b0;

    case (s_ff.state)
      SBW_ST_IDLE: begin
        // first beat one K cycle after the address
        if (k_rise && s_ff.pend_valid) begin
          nxt_s.push_valid       = 1'b1;
          nxt_s.push_entry.addr  = s_ff.pend_addr;
          nxt_s.push_entry.beat  = 1'b0;
          nxt_s.push_entry.width = width_sel_in;
          nxt_s.push_entry.sel_n = beat_sel_n;
          nxt_s.push_entry.data  = s_ff.sync2.data;
          nxt_s.cur_addr         = s_ff.pend_addr;
          nxt_s.state            = SBW_ST_BEAT1;
        end
      end
      SBW_ST_BEAT1: begin
        // second beat on the next K-bar rise with its own selects
        if (k_bar_rise) begin
          nxt_s.push_valid       = 1'b1;
          nxt_s.push_entry.addr  = s_ff.cur_addr;
          nxt_s.push_entry.beat  = 1'b1;
          nxt_s.push_entry.width = width_sel_in;
          nxt_s.push_entry.sel_n = beat_sel_n;
          nxt_s.push_entry.data  = s_ff.sync2.data;
          nxt_s.state            = SBW_ST_IDLE;
        end else if (k_rise) begin
          // K rose again without a K-bar rise: the burst is abandoned
          nxt_s.state = SBW_ST_IDLE;
        end
      end
      default: begin
        nxt_s.state = SBW_ST_IDLE;
      end
    endcase

    // a new command may arrive on the same K rise as a first beat
    if (k_rise) begin
      nxt_s.pend_valid = wr_cmd;
      nxt_s.pend_addr  = s_ff.sync2.addr;
    end

    // -------------------------------------------------------------------
    // status
    // -------------------------------------------------------------------
    // the pins cannot be stalled, so a full buffer loses the beat;
    // a loss in the clearing cycle still sets the flag
    if (overflow_clr_in) begin
      nxt_s.overflow = 1'b0;
    end
    if (s_ff.push_valid && !fifo_in_ready) begin
      nxt_s.overflow = 1'b1;
    end

    if (drain) begin
      nxt_s.beats = s_ff.beats + `SBW_CNT_W'(1);
    end

    nxt_s.pending    = fifo_out_valid | s_ff.push_valid;
    nxt_s.peek_valid = peek_en_in;
    if (peek_en_in) begin
      nxt_s.peek_data = peek_word;
    end
  end

  // -------------------------------------------------------------------
  // state register
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_ff              <= '0;
      s_ff.state        <= SBW_ST_IDLE;
      s_ff.sync1.load_n <= 1'b1;
      s_ff.sync2.load_n <= 1'b1;
      s_ff.sync1.rw_n   <= 1'b1;
      s_ff.sync2.rw_n   <= 1'b1;
      s_ff.peek_data    <= `SBW_RST_DATA;
      s_ff.beats        <= `SBW_RST_CNT;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign peek_data_out      = s_ff.peek_data;
  assign peek_valid_out     = s_ff.peek_valid;
  assign posted_pending_out = s_ff.pending;
  assign overflow_out       = s_ff.overflow;
  assign beats_written_out  = s_ff.beats;

endmodule // sbw_top
`default_nettype wire

// file: tb/sbw_top_props.sv
// concurrent checks on the ports of the byte lane write mask front end
`timescale 1ns/1ns
`default_nettype none
`include "sbw_defs.svh"
module sbw_top_props (
  // clock and reset
  input  wire logic                   clk_sys_in,
  input  wire logic                   resetn_in,
  // controls
  input  wire logic                   peek_en_in,
  input  wire logic                   overflow_clr_in,
  // observed outputs
  input  wire logic [`SBW_DATA_W-1:0] peek_data_out,
  input  wire logic                   peek_valid_out,
  input  wire logic                   posted_pending_out,
  input  wire logic                   overflow_out,
  input  wire logic [`SBW_CNT_W-1:0]  beats_written_out
);
  default clocking sbw_cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);
  // -------------------------------------------------------------------
  // sequences
  // -------------------------------------------------------------------
  sequence peek_req_s;
    peek_en_in;
  endsequence
  sequence peek_hold_s;
    peek_en_in [*2];
  endsequence
  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  peek_answer_a: assert property (peek_req_s |=> peek_valid_out)
    else $error("peek answer missing");
  peek_quiet_a: assert property (!peek_en_in |=> !peek_valid_out)
    else $error("peek valid without request");
  peek_hold_a: assert property (!peek_en_in |=> $stable(peek_data_out))
    else $error("peek data moved without request");
  commit_stall_a: assert property (peek_hold_s |=> $stable(beats_written_out))
    else $error("commit while peeking");
  count_step_a: assert property (
      16'(beats_written_out - $past(beats_written_out)) <= 16'h0001)
    else $error("beat count jumped");
  count_cause_a: assert property ($changed(beats_written_out) |-> $past(posted_pending_out))
    else $error("beat committed with nothing posted");
  loss_cause_a: assert property ($rose(overflow_out) |-> $past(posted_pending_out))
    else $error("overflow with empty buffer");
  loss_sticky_a: assert property (overflow_out && !overflow_clr_in |=> overflow_out)
    else $error("overflow flag dropped");
endmodule // sbw_top_props
`default_nettype wire

// file: tb/sbw_ctrl_model.sv
// controller-side pin model that issues write bursts
`timescale 1ns/1ns
`default_nettype none
`include "sbw_defs.svh"
module sbw_ctrl_model (
  // clock
  input  wire logic                   clk_sys_in,
  // memory pins
  output var logic                    k_out,
  output var logic                    k_bar_out,
  output var logic                    load_strobe_n_out,
  output var logic                    read_write_n_out,
  output var logic [`SBW_ADDR_W-1:0]  addr_out,
  output var logic [`SBW_DATA_W-1:0]  data_out,
  output var logic [`SBW_SEL_W-1:0]   sel_n_out,
  output var logic [`SBW_HSEL_W-1:0]  nib_n_out
);
  // clocks stand low between frames
  initial begin
    k_out = 1'b0;
    k_bar_out = 1'b0;
    load_strobe_n_out = 1'b1;
    read_write_n_out = 1'b1;
    addr_out = '0;
    data_out = '0;
    sel_n_out = '1;
    nib_n_out = '1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  // levels last 5 system cycles so the synchroniser sees every edge
  task automatic beat(input logic [35:0] d, input logic [3:0] s, input logic on_bar);
    data_out <= d;
    sel_n_out <= s;
    nib_n_out <= s[1:0];
    hold(4);
    if (on_bar) k_bar_out <= 1'b1;
    else k_out <= 1'b1;
    hold(5);
    k_out <= 1'b0;
    k_bar_out <= 1'b0;
  endtask
  task automatic write_burst(input logic [5:0] a, input logic [35:0] d0, d1,
                             input logic [3:0] s0, s1);
    hold(1);
    load_strobe_n_out <= 1'b0;
    read_write_n_out <= 1'b0;
    addr_out <= a;
    beat(data_out, sel_n_out, 1'b0);
    load_strobe_n_out <= 1'b1;
    read_write_n_out <= 1'b1;
    addr_out <= ~a;
    hold(5);
    k_bar_out <= 1'b1;
    hold(5);
    k_bar_out <= 1'b0;
    beat(d0, s0, 1'b0);
    beat(d1, s1, 1'b1);
    // released lines show the inverse, never a stale copy
    data_out <= ~d1;
    sel_n_out <= ~s1;
    nib_n_out <= ~s1[1:0];
    hold(5);
  endtask
endmodule // sbw_ctrl_model
`default_nettype wire

// file: tb/sram_byte_write_mask_bench.sv
// self-checking bench for the byte lane write mask front end
`timescale 1ns/1ns
`default_nettype none
`include "sbw_defs.svh"
module sram_byte_write_mask_bench;
  import sbw_pkg::*;
  logic             clk_sys_in = 1'b0;
  logic             resetn_in = 1'b0;
  logic             k, kb, load_n, rw_n, pend, ovf, pvalid;
  logic [5:0]       addr;
  logic [35:0]      data, pdata;
  logic [3:0]       sel;
  logic [1:0]       nib;
  sbw_width_t       wsel = SBW_X8;
  logic             clr = 1'b0;
  logic             peek_en = 1'b0;
  logic [6:0]       peek_idx = '0;
  logic [15:0]      beats, cnt;
  logic [35:0]      exp [128];
  logic [3:0]       sels [6] = '{4'hE, 4'hD, 4'hB, 4'h7, 4'hF, 4'hC};
  int               failures = 0;
  int               check_count = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  sbw_ctrl_model u_ctrl (.clk_sys_in(clk_sys_in), .k_out(k), .k_bar_out(kb),
    .load_strobe_n_out(load_n), .read_write_n_out(rw_n), .addr_out(addr),
    .data_out(data), .sel_n_out(sel), .nib_n_out(nib));
  sbw_top dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .k_in(k), .k_bar_in(kb),
    .load_strobe_n_in(load_n), .read_write_n_in(rw_n), .addr_in(addr), .data_in(data),
    .lane_write_select_n_in(sel), .half_word_write_select_n_in(nib),
    .width_sel_in(wsel), .overflow_clr_in(clr), .peek_en_in(peek_en),
    .peek_idx_in(peek_idx), .peek_data_out(pdata), .peek_valid_out(pvalid),
    .posted_pending_out(pend), .overflow_out(ovf), .beats_written_out(beats));
  // -------------------------------------------------------------------
  // expectations
  // -------------------------------------------------------------------
  function automatic logic [35:0] merge(sbw_width_t w, logic [3:0] s, logic [35:0] o, n);
    logic [35:0] en;
    en = '0;
    if (w == SBW_X8) en[7:0] = {{4{~s[1]}}, {4{~s[0]}}};
    else for (int i = 0; i < (1 << (int'(w) - 1)); i++) en[i*9 +: 9] = {9{~s[i]}};
    return (o & ~en) | (n & en);
  endfunction
  function automatic logic [35:0] rnd36();
    return 36'({$urandom, $urandom});
  endfunction
  // -------------------------------------------------------------------
  // checks and closing
  // -------------------------------------------------------------------
  task automatic check_word(input string nm, input logic [35:0] e, g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check_bit(input string nm, input logic e, g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    #1;
    while (pend !== 1'b0 && n < 200) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    check_bit("drained", 1'b0, pend);
    repeat (3) @(posedge clk_sys_in);
  endtask
  task automatic burst_check(input logic [5:0] a, input logic [35:0] d0, d1,
                             input logic [3:0] s0, s1);
    logic [35:0] m;
    u_ctrl.write_burst(a, d0, d1, s0, s1);
    exp[{a, 1'b0}] = merge(wsel, s0, exp[{a, 1'b0}], d0);
    exp[{a, 1'b1}] = merge(wsel, s1, exp[{a, 1'b1}], d1);
    cnt += 16'h0002;
    m = merge(wsel, 4'h0, '0, '1);
    wait_idle();
    for (int b = 0; b < 2; b++) begin
      peek_idx <= {a, b[0]};
      peek_en <= 1'b1;
      @(posedge clk_sys_in);
      peek_en <= 1'b0;
      #1;
      check_bit("peek valid", 1'b1, pvalid);
      check_word("row", exp[{a, b[0]}] & m, pdata & m);
      @(posedge clk_sys_in);
    end
    #1;
    check_word("beats", 36'(cnt), 36'(beats));
  endtask
  // -------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------
  initial begin
    logic [5:0] a;
    void'($urandom(32'h2d83));
    cnt = '0;
    repeat (16) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    #1;
    check_word("status", 36'h0, 36'({pend, ovf, pvalid, beats}));
    for (int w = 0; w < 4; w++) begin
      @(posedge clk_sys_in);
      wsel <= sbw_width_t'(w);
      a = 6'($urandom_range(63));
      burst_check(a, rnd36(), rnd36(), 4'h0, 4'h0);
      foreach (sels[i]) begin
        burst_check(a, rnd36(), rnd36(), sels[i], sels[(i + 1) % 6]);
      end
      repeat (4) burst_check(a, rnd36(), rnd36(), 4'($urandom), 4'($urandom));
    end
    // commits stall while peeking, so six beats overrun four entries
    @(posedge clk_sys_in);
    peek_en <= 1'b1;
    for (int i = 0; i < 3; i++) u_ctrl.write_burst(6'(i), rnd36(), rnd36(), 4'h0, 4'h0);
    #1;
    check_bit("overflow", 1'b1, ovf);
    check_bit("pending", 1'b1, pend);
    @(posedge clk_sys_in);
    peek_en <= 1'b0;
    wait_idle();
    cnt += 16'h0004;
    check_word("beats", 36'(cnt), 36'(beats));
    clr <= 1'b1;
    @(posedge clk_sys_in);
    clr <= 1'b0;
    #1;
    check_bit("overflow", 1'b0, ovf);
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    failures++;
    complete_run();
  end
endmodule // sram_byte_write_mask_bench
bind sbw_top sbw_top_props u_props (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
  .peek_en_in(peek_en_in), .overflow_clr_in(overflow_clr_in),
  .peek_data_out(peek_data_out), .peek_valid_out(peek_valid_out),
  .posted_pending_out(posted_pending_out), .overflow_out(overflow_out),
  .beats_written_out(beats_written_out));
`default_nettype wire
